// *** rtl/sbh_pkg.sv ***
package sbh_pkg;
	localparam int SBH_BUS_W       = 16;
	localparam int SBH_ADDR_W      = 11;
	localparam int SBH_BE_W        = 4;
	localparam int SBH_BE_LSB      = 12;
	localparam int SBH_DONTCARE    = 11;
	localparam int SBH_ADDR16_LSB  = 4;
	localparam int SBH_ADDR16_MSB  = 10;
	localparam int SBH_ADDR8_MSB   = 7;
	localparam int SBH_HIGH_LSB    = 8;
	localparam logic [15:0] SBH_BUS_RST  = 16'h0000;
	localparam logic [10:0] SBH_ADDR_RST = 11'h000;
	localparam logic [3:0]  SBH_BE_RST   = 4'h0;

	typedef enum logic [1:0] {
		SBH_CMD_FIRST  = 2'b01,
		SBH_CMD_SECOND = 2'b10
	} sbh_cmd_st_t;
endpackage : sbh_pkg

// *** rtl/sbh_if.sv ***
`timescale 1ns/1ns
interface sbh_if;
	import sbh_pkg::*;
	logic [15:0] host_bus_o;
	logic        host_bus_oe;
	logic [15:0] dev_bus_o;
	logic [15:0] dev_bus_oe;
	logic        cmd_sel;
	logic        wr_strobe;
	logic        rd_strobe;
	logic        bus16_mode;
	logic        chip_sleep_n;
	logic        hard_reset_n;
	logic [15:0] bus_level;

	// resolved wire: host wins, else device per bit, else pull-down
	assign bus_level = host_bus_oe ? host_bus_o : (dev_bus_o & dev_bus_oe);

	modport device (
		input  bus_level, cmd_sel, wr_strobe, rd_strobe, bus16_mode, chip_sleep_n,
		       hard_reset_n,
		output dev_bus_o, dev_bus_oe
	);
	modport host (
		input  bus_level,
		output host_bus_o, host_bus_oe, cmd_sel, wr_strobe, rd_strobe, bus16_mode,
		       chip_sleep_n, hard_reset_n
	);
endinterface : sbh_if

// *** rtl/sbh_device.sv ***
`timescale 1ns/1ns
// Functional notes
// - cmd low: every bus bit is data in 16-bit mode, only bits 7..0 in 8-bit mode
// - 16-bit cmd high: bits 15..12 byte enables
// - bit 11 ignored while cmd high
// - 16-bit cmd high: bits 10..4 address
// - 8-bit mode: host grounds bits 15..8
// - 8-bit: bits 7..4 address first write only
// - sleep low: tristate, registers to default
// - sleep release equals hard reset state
// - bus driven only after reset completes
module sbh_device
	import sbh_pkg::*;
(
	input  wire logic                           clk,        // 100 MHz clock
	input  wire logic                           nrst,       // async reset, active low
	sbh_if.device                               bus,        // shared host bus
	input  wire logic [sbh_pkg::SBH_BUS_W-1:0]  rd_data,    // data returned on reads
	output logic      [sbh_pkg::SBH_BUS_W-1:0]  wr_data,    // last data word written
	output logic                                wr_valid,   // pulse: data write taken
	output logic      [sbh_pkg::SBH_ADDR_W-1:0] addr,       // decoded address
	output logic      [sbh_pkg::SBH_BE_W-1:0]   byte_en,    // decoded byte enables
	output logic                                addr_valid  // pulse: address complete
);
	import sbh_pkg::*;

	logic                  in_reset;
	logic                  cmd_wr;
	logic                  data_wr;
	logic                  pins_live;
	logic                  read_cyc;
	logic                  drive_en;
	logic [SBH_BUS_W-1:0]  lane_en;
	logic [SBH_BUS_W-1:0]  bus_in;

	logic [SBH_BE_W-1:0]   be_field;
	logic [SBH_ADDR_W-1:0] addr16_field;
	logic [SBH_ADDR_W-1:0] addr8_field;

	logic [SBH_BUS_W-1:0]  wr_data_q;
	logic [SBH_BUS_W-1:0]  wr_data_d;
	logic [SBH_BUS_W-1:0]  rd_hold_q;
	logic [SBH_BUS_W-1:0]  rd_hold_d;
	logic [SBH_ADDR_W-1:0] addr_q;
	logic [SBH_ADDR_W-1:0] addr_d;
	logic [SBH_BE_W-1:0]   be_q;
	logic [SBH_BE_W-1:0]   be_d;
	logic                  wr_valid_q;
	logic                  wr_valid_d;
	logic                  addr_valid_q;
	logic                  addr_valid_d;
	logic                  ready_q;
	logic                  ready_d;
	sbh_cmd_st_t           cst_q;
	sbh_cmd_st_t           cst_d;

	assign in_reset = !bus.chip_sleep_n || !bus.hard_reset_n;
	assign cmd_wr   = bus.wr_strobe && bus.cmd_sel && !in_reset;
	assign data_wr  = bus.wr_strobe && !bus.cmd_sel && !in_reset;

	// field slices of a command word; bit 11 feeds neither of them
	assign be_field     = bus_in[SBH_BE_LSB +: SBH_BE_W];
	assign addr16_field = {bus_in[SBH_ADDR16_MSB:SBH_ADDR16_LSB],
	                       addr_q[SBH_ADDR16_LSB-1:0]};
	assign addr8_field  = {addr_q[SBH_ADDR_W-1:SBH_ADDR8_MSB+1],
	                       bus_in[SBH_ADDR8_MSB:SBH_ADDR16_LSB],
	                       addr_q[SBH_ADDR16_LSB-1:0]};

	// 8-bit mode needs two command writes; only the first carries address
	always_comb begin
		addr_d       = addr_q;
		be_d         = be_q;
		cst_d        = cst_q;
		addr_valid_d = 1'b0;
		if (cmd_wr) begin
			if (bus.bus16_mode) begin
				be_d   = be_field;
				addr_d = addr16_field;
				addr_valid_d = 1'b1;
			end else begin
				case (cst_q)
					SBH_CMD_FIRST: begin
						addr_d = addr8_field;
						cst_d = SBH_CMD_SECOND;
					end
					SBH_CMD_SECOND: begin
						// upper nibble is don't care on the second write
						cst_d = SBH_CMD_FIRST;
						addr_valid_d = 1'b1;
					end
					default: cst_d = SBH_CMD_FIRST;
				endcase
			end
		end
	end

	assign wr_data_d  = data_wr ? bus_in : wr_data_q;
	assign rd_hold_d  = rd_data;
	assign wr_valid_d = data_wr;
	// pins stay quiet for the first cycle after any reset or sleep release
	assign ready_d    = 1'b1;

	// each register: async reset, and held at default while sleep or hard reset is low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_data_q <= SBH_BUS_RST;
		end else if (in_reset) begin
			wr_data_q <= SBH_BUS_RST;
		end else begin
			wr_data_q <= wr_data_d;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_hold_q <= SBH_BUS_RST;
		end else if (in_reset) begin
			rd_hold_q <= SBH_BUS_RST;
		end else begin
			rd_hold_q <= rd_hold_d;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addr_q <= SBH_ADDR_RST;
		end else if (in_reset) begin
			addr_q <= SBH_ADDR_RST;
		end else begin
			addr_q <= addr_d;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			be_q <= SBH_BE_RST;
		end else if (in_reset) begin
			be_q <= SBH_BE_RST;
		end else begin
			be_q <= be_d;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cst_q <= SBH_CMD_FIRST;
		end else if (in_reset) begin
			cst_q <= SBH_CMD_FIRST;
		end else begin
			cst_q <= cst_d;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_valid_q <= 1'b0;
		end else if (in_reset) begin
			wr_valid_q <= 1'b0;
		end else begin
			wr_valid_q <= wr_valid_d;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addr_valid_q <= 1'b0;
		end else if (in_reset) begin
			addr_valid_q <= 1'b0;
		end else begin
			addr_valid_q <= addr_valid_d;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ready_q <= 1'b0;
		end else if (in_reset) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= ready_d;
		end
	end

	// outputs held off one cycle past reset release
	assign pins_live = ready_q && !in_reset;
	assign read_cyc  = bus.rd_strobe && !bus.cmd_sel;
	assign drive_en  = pins_live && read_cyc;

	genvar gi;
	generate
		for (gi = 0; gi < SBH_BUS_W; gi++) begin : g_lane
			// 8-bit mode: upper byte is grounded by the host, never sampled or driven
			assign lane_en[gi]        = bus.bus16_mode || (gi < SBH_HIGH_LSB);
			assign bus_in[gi]         = bus.bus_level[gi] && lane_en[gi];
			assign bus.dev_bus_oe[gi] = drive_en && lane_en[gi];
			// pins show a registered copy, so read data is one cycle old
			assign bus.dev_bus_o[gi]  = rd_hold_q[gi];
		end
	endgenerate

	// all data outputs come straight from flops
	assign wr_data    = wr_data_q;
	assign wr_valid   = wr_valid_q;
	assign addr       = addr_q;
	assign byte_en    = be_q;
	assign addr_valid = addr_valid_q;
endmodule : sbh_device

// *** rtl/sbh_host.sv ***
`timescale 1ns/1ns
module sbh_host
	import sbh_pkg::*;
(
	input  wire logic                          clk,       // 100 MHz clock
	input  wire logic                          nrst,      // async reset, active low
	sbh_if.host                                bus,       // shared host bus
	input  wire logic                          mode16,    // 1: 16-bit bus mode
	input  wire logic                          sleep_n,   // chip sleep request, active low
	input  wire logic                          rst_n_req, // device hard reset, active low
	input  wire logic                          req,       // pulse: start one bus cycle
	input  wire logic                          is_cmd,    // cycle uses cmd high
	input  wire logic                          is_read,   // cycle is a read
	input  wire logic [sbh_pkg::SBH_BUS_W-1:0] wdata,     // data, or address and enables
	output logic      [sbh_pkg::SBH_BUS_W-1:0] rdata,     // captured read data
	output logic                               rvalid     // pulse: rdata valid
);
	import sbh_pkg::*;

	logic        act_q, cmd_q, rd_q, rvalid_q;
	logic [15:0] out_q, rdata_q;
	logic [15:0] wd_masked;

	// upper byte kept at ground in 8-bit mode
	assign wd_masked = mode16 ? wdata : {8'h00, wdata[SBH_HIGH_LSB-1:0]};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			act_q    <= 1'b0;
			cmd_q    <= 1'b0;
			rd_q     <= 1'b0;
			out_q    <= SBH_BUS_RST;
			rdata_q  <= SBH_BUS_RST;
			rvalid_q <= 1'b0;
		end else begin
			act_q    <= req;
			cmd_q    <= req ? is_cmd : cmd_q;
			// a read with cmd high stays a read, never turns into a command write
			rd_q     <= req ? is_read : 1'b0;
			out_q    <= req ? wd_masked : out_q;
			rvalid_q <= rd_q;
			rdata_q  <= rd_q ? bus.bus_level : rdata_q;
		end
	end

	assign bus.bus16_mode   = mode16;
	assign bus.chip_sleep_n = sleep_n;
	assign bus.hard_reset_n = rst_n_req;
	assign bus.cmd_sel      = cmd_q;
	assign bus.rd_strobe    = act_q && rd_q;
	assign bus.wr_strobe    = act_q && !rd_q;
	assign bus.host_bus_oe  = act_q && !rd_q;
	assign bus.host_bus_o   = out_q;
	assign rdata            = rdata_q;
	assign rvalid           = rvalid_q;
endmodule : sbh_host

// *** testbench/sbh_chk_sva.sv ***
`timescale 1ns/1ns
module sbh_chk_sva (
	input wire logic        clk,          // clock
	input wire logic        nrst,         // async reset
	input wire logic [15:0] host_bus_o,   // host data
	input wire logic        host_bus_oe,  // host drive
	input wire logic [15:0] dev_bus_oe,   // device drive
	input wire logic        cmd_sel,      // command select
	input wire logic        wr_strobe,    // write pulse
	input wire logic        rd_strobe,    // read pulse
	input wire logic        bus16_mode,   // bus width
	input wire logic        chip_sleep_n, // sleep pin
	input wire logic        hard_reset_n  // reset pin
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	chk_cmd_no_drive: assert property (cmd_sel |-> dev_bus_oe == 16'h0000)
		else $error("device drives in command");
	chk_sleep_float: assert property ((!chip_sleep_n)[*2] |-> dev_bus_oe == 16'h0000)
		else $error("device drives in sleep");
	chk_reset_float: assert property ((!hard_reset_n)[*2] |-> dev_bus_oe == 16'h0000)
		else $error("device drives in reset");
	chk_wake_quiet: assert property ($rose(chip_sleep_n) |-> dev_bus_oe == 16'h0000)
		else $error("device drives on wake");
	chk_drive_read: assert property (|dev_bus_oe |-> rd_strobe && !cmd_sel)
		else $error("device drives outside read");
	chk_read_full: assert property (rd_strobe && !cmd_sel && chip_sleep_n && hard_reset_n
		&& $past(chip_sleep_n) && $past(hard_reset_n)
		|-> dev_bus_oe == (bus16_mode ? 16'hFFFF : 16'h00FF))
		else $error("read not driven on all bits");
	chk_high_grounded: assert property (host_bus_oe && !bus16_mode |-> host_bus_o[15:8] == 8'h00)
		else $error("high byte not grounded");
	chk_no_clash: assert property (rd_strobe |-> !host_bus_oe)
		else $error("host drives during read");
	chk_write_drive: assert property (wr_strobe |-> host_bus_oe)
		else $error("write without host drive");
	cover property (rd_strobe && !cmd_sel);
	cover property (wr_strobe && cmd_sel && bus16_mode);
	cover property (wr_strobe && cmd_sel && !bus16_mode);
endmodule : sbh_chk_sva

// *** testbench/tb_sbh.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
	$display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb_sbh;
	logic        clk = 0, nrst = 0, mode16 = 1, sleep_n = 1, rst_n_req = 1;
	logic        req = 0, is_cmd = 0, is_read = 0, wr_valid, addr_valid, rvalid;
	logic [15:0] wdata = 0, rd_data = 0, wr_data, rdata;
	logic [10:0] addr;
	logic [3:0]  byte_en;
	int          n_fail = 0, checks = 0, cyc = 0;
	always #5 clk = ~clk;
	sbh_if sbh_if_i ();
	sbh_device sbh_device_i (.clk, .nrst, .bus(sbh_if_i), .rd_data, .wr_data, .wr_valid, .addr,
		.byte_en, .addr_valid);
	sbh_host sbh_host_i (.clk, .nrst, .bus(sbh_if_i), .mode16, .sleep_n, .rst_n_req, .req,
		.is_cmd, .is_read, .wdata, .rdata, .rvalid);
	sbh_chk_sva sbh_chk_sva_i (.clk, .nrst, .host_bus_o(sbh_if_i.host_bus_o),
		.host_bus_oe(sbh_if_i.host_bus_oe), .dev_bus_oe(sbh_if_i.dev_bus_oe),
		.cmd_sel(sbh_if_i.cmd_sel), .wr_strobe(sbh_if_i.wr_strobe),
		.rd_strobe(sbh_if_i.rd_strobe), .bus16_mode(sbh_if_i.bus16_mode),
		.chip_sleep_n(sbh_if_i.chip_sleep_n), .hard_reset_n(sbh_if_i.hard_reset_n));
	task automatic test_done();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	// strobe in the cycle after req is taken; answers stand in the cycle after that
	task automatic op(input logic c, input logic r, input logic [15:0] d);
		@(negedge clk);
		req = 1;
		is_cmd = c;
		is_read = r;
		wdata = d;
		@(negedge clk);
		req = 0;
		@(negedge clk);
	endtask : op
	task automatic t_data();
		op(0, 0, 16'hA55A);
		`CHK(wr_valid, 1'b1)
		`CHK(wr_data, 16'hA55A)
		$display("data write done");
	endtask : t_data
	task automatic t_cmd16();
		op(1, 0, 16'hAB50);
		`CHK(addr_valid, 1'b1)
		`CHK(addr, 11'h350)
		`CHK(byte_en, 4'hA)
		$display("wide command done");
	endtask : t_cmd16
	task automatic t_cmd8();
		mode16 = 0;
		op(1, 0, 16'h00A0);
		op(1, 0, 16'h0050);
		`CHK(addr_valid, 1'b1)
		`CHK(addr[7:4], 4'hA)
		mode16 = 1;
		$display("narrow command done");
	endtask : t_cmd8
	task automatic t_read();
		rd_data = 16'h5AC3;
		op(0, 1, 16'h0000);
		`CHK(rvalid, 1'b1)
		`CHK(rdata, 16'h5AC3)
		op(1, 1, 16'h0000);
		`CHK(rdata, 16'h0000)
		`CHK(addr_valid, 1'b0)
		mode16 = 0;
		op(0, 1, 16'h0000);
		`CHK(rdata, 16'h00C3)
		mode16 = 1;
		$display("read done");
	endtask : t_read
	task automatic t_sleep();
		sleep_n = 0;
		op(0, 0, 16'h1234);
		`CHK(wr_valid, 1'b0)
		`CHK(addr, 11'h000)
		`CHK(wr_data, 16'h0000)
		sleep_n = 1;
		op(1, 0, 16'hF010);
		`CHK(byte_en, 4'hF)
		`CHK(addr, 11'h010)
		rst_n_req = 0;
		op(0, 0, 16'h0000);
		`CHK(byte_en, 4'h0)
		rst_n_req = 1;
		repeat (2) @(negedge clk);
		$display("sleep done");
	endtask : t_sleep
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		@(negedge clk);
		nrst = 1;
		repeat (2) @(negedge clk);
		t_data();
		t_cmd16();
		t_cmd8();
		t_read();
		t_sleep();
		t_data();
		test_done();
	end
endmodule : tb_sbh
